// File: common/sfwp_pkg.sv
// Constants and types shared by the serial flash write-protection block.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
package sfwp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LASTCMD = 8'h08;
  localparam logic [7:0] ADDR_LASTADDR = 8'h0c;
  localparam int CTRL_QUAD = 0;
  localparam int CTRL_FACT_LOCK = 1;
  localparam int ST_WEL = 0;
  localparam int ST_BP_LO = 1;
  localparam int ST_STATUS_WRITE_DISABLE_BIT = 5;
  localparam int ST_PROTECT_SELECT_CMD = 6;
  localparam int ST_SECURED = 7;
  localparam int ST_SLEEP = 8;
  localparam int ST_SEC_LO = 9;
  localparam int ST_HWPROT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM = 8'h38;
  localparam logic [7:0] CMD_CONTINUOUS_PROGRAM = 8'had;
  localparam logic [7:0] CMD_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] CMD_HALF_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] CMD_LARGE_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] CMD_CHIP_WIPE = 8'h60;
  localparam logic [7:0] CMD_SINGLE_LOCK = 8'h36;
  localparam logic [7:0] CMD_SINGLE_UNLOCK = 8'h39;
  localparam logic [7:0] CMD_GANG_LOCK = 8'h7e;
  localparam logic [7:0] CMD_GANG_UNLOCK = 8'h98;
  localparam logic [7:0] CMD_SLEEP = 8'hb9;
  localparam logic [7:0] CMD_WAKE_FROM_SLEEP = 8'hab;
  localparam logic [7:0] CMD_SIGNATURE_READ = 8'h90;
  localparam logic [7:0] CMD_PROTECT_SELECT = 8'h68;
  localparam logic [7:0] CMD_ENTER_SECURED = 8'hb1;
  localparam logic [7:0] CMD_EXIT_SECURED = 8'hc1;
  localparam logic [7:0] CMD_SECURITY_WRITE = 8'h2f;

  // ----------------------------------------------------------------
  // Status byte fields, bit counts, secured area map
  // ----------------------------------------------------------------
  localparam int SW_BP_LO = 2;
  localparam int SW_STATUS_WRITE_DISABLE_BIT = 7;
  localparam logic [15:0] BITS_OP = 16'd8;
  localparam logic [15:0] BITS_ONE_DATA = 16'd16;
  localparam logic [15:0] BITS_ADDR = 16'd32;
  localparam logic [15:0] BITS_PROG = 16'd40;
  localparam int NUM_BLOCKS = 256;
  localparam logic [8:0] BLOCKS_ALL = 9'd256;
  localparam logic [23:0] SEC_SERIAL_LAST = 24'h00000f;
  localparam logic [23:0] SEC_LAST = 24'h0001ff;
  localparam int SEC_FACTORY = 0;
  localparam int SEC_CUSTOMER = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {ST_STANDBY, ST_SHIFT} sfwp_state_e;
  typedef enum logic [2:0] {OP_NONE, OP_PROGRAM, OP_SECTOR, OP_HALF_BLOCK, OP_BLOCK, OP_CHIP, OP_SEC_PROGRAM}
    sfwp_op_e;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic io0;
    logic write_protect_pin_io2;
  } sfwp_pins_s;
  typedef struct packed {
    logic go;
    sfwp_op_e op;
    logic [23:0] addr;
    logic [7:0] data;
  } sfwp_mem_req_s;

endpackage

// File: src/sfwp_core.sv
// Write-protection front end of a serial flash: watches the host pins, filters commands, drives memory requests.
// Assumes pins from another clock domain, an AXI4-Lite master on aclk, and a memory core that obeys mem_req.go.
//
// What this block does
// - Reset puts the command machine into standby with no command received.
// - A command not ending on a byte boundary at deselect is rejected.
// - Program, erase and status write are ignored unless the write latch is set.
// - Write latch clears at reset and when any write-type command other than protect select and security write completes.
// - In deep sleep only wake and signature read are obeyed.
// - Protect value 1 to 7 makes the top 2 to 128 blocks read-only outside individual mode.
// - Protect value 8 to 15 makes all 256 blocks read-only outside individual mode.
// - Chip erase is only accepted when the protect value is zero.
// - Hardware protection freezes protect bits and the status write-disable bit.
// - Hardware protection is off while four data lines are in use.
// - In individual mode single lock and unlock change one addressed block.
// - In individual mode gang lock and unlock change every block.
// - Security bit 0 reports the factory lock.
// - Security write command sets the customer lock bit 1.
// - A set lock and the area it guards do not change again until reset.
// - Secured mode blocks every access to the main array.
// - Secured area: serial number at 000-00F, customer region at 010-1FF.
// - Memory changes only after a complete valid command sequence.
`timescale 1ns/1ps

module sfwp_core
  import sfwp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Host pins
  input wire sfwp_pins_s pins,
  // Memory core request
  output sfwp_mem_req_s mem_req,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sfwp_pins_s p1;
    sfwp_pins_s p2;
    sfwp_pins_s p3;
    sfwp_state_e st;
    logic sleep;
    logic secured;
    logic write_latch_flag;
    logic [3:0] block_protect_bits;
    logic status_write_disable_bit;
    logic protect_select_cmd;
    logic quad;
    logic [1:0] sec;
    logic [NUM_BLOCKS-1:0] lock;
    logic [7:0] sh;
    logic [15:0] bits;
    logic [7:0] cmd;
    logic [23:0] adr;
    logic [7:0] dat;
    sfwp_mem_req_s mem;
    logic [7:0] last_cmd;
    logic last_ok;
    logic last_rej;
    logic aw_got;
    logic w_got;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sfwp_regs_s;

  sfwp_regs_s r;
  sfwp_regs_s n;
  logic hw_prot;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic byte_ok;

  // Block protection by group bits or by individual locks
  function automatic logic blk_prot(input logic [7:0] blk, input logic [3:0] bp, input logic ws,
                                    input logic [NUM_BLOCKS-1:0] lk);
    logic res;
    res = 1'b0;
    if (ws) begin
      res = lk[blk];
    end else if (bp[3]) begin
      res = 1'b1;
    end else if (bp != 4'h0) begin
      res = ({1'b0, blk} >= (BLOCKS_ALL - (9'd1 << bp[2:0])));
    end
    return res;
  endfunction

  // Pin edges, seen only on the second and third stages
  assign cs_fall = !r.p2.cs_n && r.p3.cs_n;
  assign cs_rise = r.p2.cs_n && !r.p3.cs_n;
  assign sclk_rise = r.p2.sclk && !r.p3.sclk;
  assign byte_ok = (r.bits[2:0] == 3'h0) && (r.bits != 16'h0);
  assign hw_prot = r.status_write_disable_bit && !r.p2.write_protect_pin_io2 && !r.quad;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] nsh;
    logic wr_ok;
    logic [7:0] blk;
    nsh = {r.sh[6:0], r.p2.io0};
    blk = r.adr[23:16];
    wr_ok = 1'b0;
    n = r;
    n.p1 = pins;
    n.p2 = r.p1;
    n.p3 = r.p2;
    n.mem.go = 1'b0;

    // Command shifting and decode at deselect
    case (r.st)
      ST_STANDBY: begin
        if (cs_fall) begin
          n.st = ST_SHIFT;
          n.bits = 16'h0;
          n.cmd = 8'h00;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          n.st = ST_STANDBY;
          n.last_cmd = r.cmd;
          n.last_ok = 1'b0;
          n.last_rej = 1'b1;
          wr_ok = byte_ok && r.write_latch_flag;
          if (!byte_ok) begin
            n.last_rej = 1'b1;
          end else if (r.sleep) begin
            if (r.cmd == CMD_WAKE_FROM_SLEEP || r.cmd == CMD_SIGNATURE_READ) begin
              n.sleep = 1'b0;
              n.last_ok = 1'b1;
              n.last_rej = 1'b0;
            end
          end else begin
            n.last_ok = 1'b1;
            n.last_rej = 1'b0;
            if (r.cmd == CMD_WRITE_ENABLE) begin
              n.write_latch_flag = 1'b1;
            end else if (r.cmd == CMD_WRITE_DISABLE) begin
              n.write_latch_flag = 1'b0;
            end else if (r.cmd == CMD_SLEEP) begin
              n.sleep = 1'b1;
            end else if (r.cmd == CMD_ENTER_SECURED) begin
              n.secured = 1'b1;
            end else if (r.cmd == CMD_EXIT_SECURED) begin
              n.secured = 1'b0;
            end else if (r.cmd == CMD_SECURITY_WRITE) begin
              n.sec[SEC_CUSTOMER] = 1'b1;
            end else if (r.cmd == CMD_PROTECT_SELECT && wr_ok) begin
              n.protect_select_cmd = 1'b1;
            end else if (r.cmd == CMD_STATUS_WRITE && wr_ok && r.bits >= BITS_ONE_DATA) begin
              n.write_latch_flag = 1'b0;
              if (!hw_prot) begin
                n.block_protect_bits = r.dat[SW_BP_LO +: 4];
                n.status_write_disable_bit = r.dat[SW_STATUS_WRITE_DISABLE_BIT];
              end
            end else if ((r.cmd == CMD_PAGE_PROGRAM || r.cmd == CMD_QUAD_PAGE_PROGRAM
                          || r.cmd == CMD_CONTINUOUS_PROGRAM) && wr_ok && r.bits >= BITS_PROG) begin
              n.write_latch_flag = 1'b0;
              n.mem.addr = r.adr;
              n.mem.data = r.dat;
              if (r.secured) begin
                // Serial number guarded by factory lock, rest by customer lock
                if (r.adr <= SEC_SERIAL_LAST) begin
                  n.mem.go = !r.sec[SEC_FACTORY];
                end else begin
                  n.mem.go = (r.adr <= SEC_LAST) && !r.sec[SEC_CUSTOMER];
                end
                n.mem.op = OP_SEC_PROGRAM;
              end else begin
                n.mem.go = !blk_prot(blk, r.block_protect_bits, r.protect_select_cmd, r.lock);
                n.mem.op = OP_PROGRAM;
              end
            end else if ((r.cmd == CMD_SECTOR_WIPE || r.cmd == CMD_HALF_BLOCK_WIPE
                          || r.cmd == CMD_LARGE_BLOCK_WIPE) && wr_ok && r.bits >= BITS_ADDR) begin
              n.write_latch_flag = 1'b0;
              n.mem.addr = r.adr;
              n.mem.go = !r.secured && !blk_prot(blk, r.block_protect_bits, r.protect_select_cmd, r.lock);
              n.mem.op = (r.cmd == CMD_SECTOR_WIPE) ? OP_SECTOR
                       : (r.cmd == CMD_HALF_BLOCK_WIPE) ? OP_HALF_BLOCK : OP_BLOCK;
            end else if (r.cmd == CMD_CHIP_WIPE && wr_ok) begin
              n.write_latch_flag = 1'b0;
              n.mem.addr = 24'h000000;
              n.mem.op = OP_CHIP;
              n.mem.go = !r.secured && (r.block_protect_bits == 4'h0) && !(r.protect_select_cmd && (|r.lock));
            end else if ((r.cmd == CMD_SINGLE_LOCK || r.cmd == CMD_SINGLE_UNLOCK) && wr_ok
                         && r.bits >= BITS_ADDR) begin
              n.write_latch_flag = 1'b0;
              if (r.protect_select_cmd && !r.secured) begin
                n.lock[blk] = (r.cmd == CMD_SINGLE_LOCK);
              end
            end else if ((r.cmd == CMD_GANG_LOCK || r.cmd == CMD_GANG_UNLOCK) && wr_ok) begin
              n.write_latch_flag = 1'b0;
              if (r.protect_select_cmd && !r.secured) begin
                n.lock = (r.cmd == CMD_GANG_LOCK) ? '1 : '0;
              end
            end else begin
              n.last_ok = 1'b0;
              n.last_rej = 1'b1;
            end
          end
        end else if (sclk_rise) begin
          // Opcode, three address bytes, then data
          n.sh = nsh;
          n.bits = (r.bits == 16'hffff) ? r.bits : r.bits + 16'h1;
          if (n.bits == BITS_OP) begin
            n.cmd = nsh;
          end
          if (n.bits[2:0] == 3'h0 && n.bits > BITS_OP && n.bits <= BITS_ADDR) begin
            n.adr = {r.adr[15:0], nsh};
          end
          if (n.bits == BITS_ONE_DATA || n.bits == BITS_PROG) begin
            n.dat = nsh;
          end
        end
      end
      default: n.st = ST_STANDBY;
    endcase

    // AXI write channel
    if (awvalid && r.awready) begin
      n.aw_got = 1'b1;
      n.awa = awaddr;
    end
    if (wvalid && r.wready) begin
      n.w_got = 1'b1;
      n.wd = wdata;
      n.ws = wstrb;
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      if (r.awa == ADDR_CTRL) begin
        if (r.ws[0]) begin
          n.quad = r.wd[CTRL_QUAD];
          n.sec[SEC_FACTORY] = r.sec[SEC_FACTORY] | r.wd[CTRL_FACT_LOCK];
        end
      end else if (r.awa == ADDR_STATUS || r.awa == ADDR_LASTCMD || r.awa == ADDR_LASTADDR) begin
        n.bresp = RESP_OKAY;
      end else begin
        n.bresp = RESP_SLVERR;
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    // AXI read channel
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h00000000;
      if (araddr == ADDR_CTRL) begin
        n.rdata[CTRL_QUAD] = r.quad;
        n.rdata[CTRL_FACT_LOCK] = r.sec[SEC_FACTORY];
      end else if (araddr == ADDR_STATUS) begin
        n.rdata[ST_WEL] = r.write_latch_flag;
        n.rdata[ST_BP_LO +: 4] = r.block_protect_bits;
        n.rdata[ST_STATUS_WRITE_DISABLE_BIT] = r.status_write_disable_bit;
        n.rdata[ST_PROTECT_SELECT_CMD] = r.protect_select_cmd;
        n.rdata[ST_SECURED] = r.secured;
        n.rdata[ST_SLEEP] = r.sleep;
        n.rdata[ST_SEC_LO +: 2] = r.sec;
        n.rdata[ST_HWPROT] = hw_prot;
      end else if (araddr == ADDR_LASTCMD) begin
        n.rdata[9:0] = {r.last_rej, r.last_ok, r.last_cmd};
      end else if (araddr == ADDR_LASTADDR) begin
        n.rdata[23:0] = r.adr;
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end
    n.arready = !n.rvalid;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.p1.cs_n <= 1'b1;
      r.p2.cs_n <= 1'b1;
      r.p3.cs_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign mem_req = r.mem;
  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reset_standby: assert property (@(posedge aclk) !aresetn |=> r.st == ST_STANDBY && !r.write_latch_flag)
    else $error("not in standby after reset");
  chk_byte_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    r.mem.go |-> $past(r.bits[2:0]) == 3'h0 && $past(cs_rise))
    else $error("request from partial byte");
  chk_latch_needed: assert property (@(posedge aclk) disable iff (!aresetn)
    r.mem.go |-> $past(r.write_latch_flag) && !r.write_latch_flag)
    else $error("write without latch or latch kept");
  chk_sleep_filter: assert property (@(posedge aclk) disable iff (!aresetn)
    r.mem.go |-> !$past(r.sleep))
    else $error("write while sleeping");
  chk_all_protect: assert property (@(posedge aclk) disable iff (!aresetn)
    r.mem.go && r.mem.op == OP_PROGRAM |-> !($past(r.block_protect_bits[3]) && !$past(r.protect_select_cmd)))
    else $error("program inside fully protected array");
  chk_top_protect: assert property (@(posedge aclk) disable iff (!aresetn)
    r.mem.go && r.mem.op != OP_SEC_PROGRAM && !$past(r.protect_select_cmd) && $past(r.block_protect_bits) == 4'h1
    |-> r.mem.addr[23:16] < 8'hfe)
    else $error("write into top two blocks");
  chk_chip_erase: assert property (@(posedge aclk) disable iff (!aresetn)
    r.mem.go && r.mem.op == OP_CHIP |-> $past(r.block_protect_bits) == 4'h0)
    else $error("chip erase with protect bits set");
  chk_hw_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_prot |=> $stable(r.block_protect_bits) && r.status_write_disable_bit)
    else $error("protect bits changed under hardware protection");
  chk_lock_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    r.sec[SEC_CUSTOMER] |=> r.sec[SEC_CUSTOMER] ##1 r.sec[SEC_CUSTOMER])
    else $error("customer lock cleared");
  chk_secured_map: assert property (@(posedge aclk) disable iff (!aresetn)
    r.mem.go |-> (r.mem.op == OP_SEC_PROGRAM) == $past(r.secured)
    && (r.mem.op != OP_SEC_PROGRAM || r.mem.addr <= SEC_LAST))
    else $error("main array touched in secured mode");

endmodule // sfwp_core

// File: verif/sfwp_core_bench.sv
// Self-checking bench: AXI4-Lite master tasks and a host pin model around the block.
// Assumes a 100 MHz aclk and a 160 ns host serial clock.
`timescale 1ns/1ps

module sfwp_core_bench;
  import sfwp_pkg::*;

  // ------------------------------------------
  // Signals
  // ------------------------------------------
  logic aclk;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  sfwp_pins_s pins;
  sfwp_mem_req_s mem_req;
  int err_count = 0, checks = 0, go_cnt = 0, i, n;

  sfwp_core sfwp_core_i (.aclk(aclk), .aresetn(aresetn), .pins(pins), .mem_req(mem_req),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  sfwp_host_model sfwp_host_model_i (.aclk(aclk), .pins(pins));

  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Count memory requests
  always @(posedge aclk) if (mem_req.go === 1'b1) go_cnt++;

  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tmo(input int k);
    if (k >= 50) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(k);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(k);
  endtask

  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    axi_rd(ADDR_STATUS);
    chk("status", d & m, e);
  endtask

  task automatic host(input logic [7:0] op, input logic [23:0] a, input int nb);
    sfwp_host_model_i.send({op, a, 8'h5a, 8'h00}, nb);
  endtask

  task automatic wsr(input logic [7:0] b);
    host(CMD_WRITE_ENABLE, 24'h0, 8);
    host(CMD_STATUS_WRITE, {b, 16'h0}, 16);
  endtask

  task automatic run(input logic [7:0] op, input logic [23:0] a, input int nb, input logic [31:0] ng);
    int g;
    g = go_cnt;
    host(CMD_WRITE_ENABLE, 24'h0, 8);
    host(op, a, nb);
    chk("go", 32'(go_cnt - g), ng);
    if (ng == 1) chk("addr", {8'h0, mem_req.addr}, {8'h0, a});
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic s_basic;
    logic [7:0] ops [7] = '{CMD_WRITE_DISABLE, CMD_CONTINUOUS_PROGRAM, CMD_QUAD_PAGE_PROGRAM, CMD_SECTOR_WIPE,
      CMD_HALF_BLOCK_WIPE, CMD_LARGE_BLOCK_WIPE, CMD_CHIP_WIPE};
    int lens [7] = '{8, 40, 40, 32, 32, 32, 8};
    stat(32'hfff, 32'h0);
    axi_rd(8'h10);
    chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(8'h10, 32'h0);
    chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    host(CMD_PAGE_PROGRAM, 24'h000100, 40);
    chk("go", 32'(go_cnt), 32'h0);
    run(CMD_PAGE_PROGRAM, 24'h000100, 40, 1);
    chk("op", {29'h0, mem_req.op}, {29'h0, OP_PROGRAM});
    chk("data", {24'h0, mem_req.data}, 32'h5a);
    axi_rd(ADDR_LASTADDR);
    chk("lastaddr", d, 32'h000100);
    stat(32'h1, 32'h0);
    run(CMD_PAGE_PROGRAM, 24'h000100, 41, 0);
    host(CMD_WRITE_DISABLE, 24'h0, 8);
    host(CMD_WRITE_ENABLE, 24'h0, 7);
    stat(32'h1, 32'h0);
    for (i = 0; i < 7; i++) begin
      host(CMD_WRITE_ENABLE, 24'h0, 8);
      stat(32'h1, 32'h1);
      host(ops[i], 24'h0, lens[i]);
      stat(32'h1, 32'h0);
    end
  endtask

  task automatic s_group;
    for (i = 0; i < 16; i++) begin
      wsr(8'(i << SW_BP_LO));
      stat(32'h1f, 32'(i << ST_BP_LO));
      n = (i == 0) ? 0 : (i >= 8) ? 256 : (2 << (i - 1));
      if (n > 0) run(CMD_PAGE_PROGRAM, 24'((256 - n) << 16), 40, 0);
      if (n < 256) run(CMD_PAGE_PROGRAM, 24'((255 - n) << 16), 40, 1);
      run(CMD_CHIP_WIPE, 24'h0, 8, 32'(i == 0));
    end
    wsr(8'h00);
  endtask

  task automatic s_hw;
    wsr(8'h80);
    @(posedge aclk);
    sfwp_host_model_i.wp_n <= 1'b0;
    repeat (3) @(posedge aclk); // Pin passes two sync stages first
    stat(32'h800, 32'h800);
    wsr(8'h0c);
    stat(32'h3e, 32'h20);
    axi_wr(ADDR_CTRL, 32'h1);
    stat(32'h800, 32'h0);
    wsr(8'h8c);
    stat(32'h3e, 32'h26);
    axi_wr(ADDR_CTRL, 32'h0);
    @(posedge aclk);
    sfwp_host_model_i.wp_n <= 1'b1;
    repeat (3) @(posedge aclk); // Pin passes two sync stages first
    stat(32'h800, 32'h0);
    wsr(8'h00);
    stat(32'h3e, 32'h0);
  endtask

  task automatic s_sleep;
    host(CMD_SLEEP, 24'h0, 8);
    stat(32'h100, 32'h100);
    run(CMD_PAGE_PROGRAM, 24'h000100, 40, 0);
    axi_rd(ADDR_LASTCMD);
    chk("lastcmd", d & 32'h3ff, {22'h0, 2'b10, CMD_PAGE_PROGRAM});
    stat(32'h1, 32'h0);
    host(CMD_SIGNATURE_READ, 24'h0, 32);
    axi_rd(ADDR_LASTCMD);
    chk("lastcmd", d & 32'h3ff, {22'h0, 2'b01, CMD_SIGNATURE_READ});
    host(CMD_SLEEP, 24'h0, 8);
    stat(32'h100, 32'h100);
    host(CMD_WAKE_FROM_SLEEP, 24'h0, 8);
    stat(32'h100, 32'h0);
  endtask

  task automatic s_indiv;
    host(CMD_WRITE_ENABLE, 24'h0, 8);
    host(CMD_PROTECT_SELECT, 24'h0, 8);
    stat(32'h40, 32'h40);
    run(CMD_SINGLE_LOCK, 24'h120000, 32, 0);
    stat(32'h1, 32'h0);
    run(CMD_PAGE_PROGRAM, 24'h120000, 40, 0);
    run(CMD_PAGE_PROGRAM, 24'h130000, 40, 1);
    run(CMD_SINGLE_UNLOCK, 24'h120000, 32, 0);
    run(CMD_PAGE_PROGRAM, 24'h120000, 40, 1);
    run(CMD_GANG_LOCK, 24'h0, 8, 0);
    stat(32'h1, 32'h0);
    run(CMD_PAGE_PROGRAM, 24'h010000, 40, 0);
    run(CMD_GANG_UNLOCK, 24'h0, 8, 0);
    run(CMD_PAGE_PROGRAM, 24'h010000, 40, 1);
  endtask

  task automatic s_secure;
    axi_wr(ADDR_CTRL, 32'h2);
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    stat(32'h600, 32'h200);
    host(CMD_ENTER_SECURED, 24'h0, 8);
    stat(32'h80, 32'h80);
    run(CMD_PAGE_PROGRAM, 24'h000005, 40, 0);
    run(CMD_PAGE_PROGRAM, 24'h000010, 40, 1);
    chk("op", {29'h0, mem_req.op}, {29'h0, OP_SEC_PROGRAM});
    run(CMD_PAGE_PROGRAM, 24'h000200, 40, 0);
    run(CMD_SECTOR_WIPE, 24'h0, 32, 0);
    host(CMD_SECURITY_WRITE, 24'h0, 8);
    stat(32'h600, 32'h600);
    run(CMD_PAGE_PROGRAM, 24'h000010, 40, 0);
    axi_wr(ADDR_CTRL, 32'h0);
    stat(32'h200, 32'h200);
    host(CMD_EXIT_SECURED, 24'h0, 8);
    stat(32'h80, 32'h0);
    run(CMD_PAGE_PROGRAM, 24'h000010, 40, 1);
  endtask

  // Main sequence
  initial begin
    do_reset();
    s_basic();
    s_group();
    s_hw();
    s_sleep();
    s_indiv();
    do_reset();
    s_secure();
    test_done();
  end
endmodule // sfwp_core_bench

// File: verif/sfwp_host_model.sv
// Host model: drives select, serial clock and data pins of the flash.
// Assumes aclk paces every pin change; the bench calls send and sets wp_n.
`timescale 1ns/1ps

module sfwp_host_model
  import sfwp_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Pins toward the block
  output sfwp_pins_s pins
);
  // ------------------------------------------
  // Pin levels
  // ------------------------------------------
  logic cs_n = 1'b1;
  logic sclk = 1'b0;
  logic io0 = 1'b0;
  logic wp_n = 1'b1;

  // Pack the pins for the block
  assign pins = '{cs_n: cs_n, sclk: sclk, io0: io0, write_protect_pin_io2: wp_n};

  // ------------------------------------------
  // One framed command, MSB first, clock parked low between frames
  // ------------------------------------------
  task automatic send(input logic [47:0] v, input int n);
    int i;
    @(posedge aclk);
    cs_n <= 1'b0;
    for (i = 0; i < n; i++) begin
      repeat (8) @(posedge aclk);
      sclk <= 1'b0;
      io0 <= v[47-i];
      repeat (8) @(posedge aclk);
      sclk <= 1'b1;
    end
    repeat (8) @(posedge aclk);
    sclk <= 1'b0;
    repeat (8) @(posedge aclk);
    cs_n <= 1'b1;
    io0 <= ~io0; // Released line shows no stale bit
    repeat (16) @(posedge aclk);
  endtask
endmodule // sfwp_host_model
